// ### logic/cme_pkg.sv
// shared constants and types of the move/math/logic execution datapath
package cme_pkg;
	localparam int         WORD_W        = 16;
	localparam int         INSTR_W       = 24;
	localparam logic [4:0] DIV_LAST      = 5'h11;
	localparam logic [4:0] DIV_STEP_LAST = 5'h10;
	localparam logic [4:0] DIV_CNT_RST   = 5'h00;
	localparam logic [2:0] CYC_ONE       = 3'h1;
	localparam logic [2:0] CYC_TWO       = 3'h2;
	localparam logic [2:0] CYC_THREE     = 3'h3;
	localparam logic [2:0] CYC_NONE      = 3'h0;
	localparam logic [1:0] WORDS_ONE     = 2'h1;
	localparam logic [1:0] WORDS_TWO     = 2'h2;
	localparam logic [15:0] FILL_ZERO    = 16'h0000;
	localparam logic [15:0] FILL_ONES    = 16'hffff;
	localparam logic [8:0] BCD_ADJ_LO    = 9'h006;
	localparam logic [8:0] BCD_ADJ_HI    = 9'h060;
	localparam logic [3:0] BCD_LIMIT     = 4'h9;
	localparam logic       CARRY_RST     = 1'b0;
	localparam logic       DC_RST        = 1'b0;
	localparam logic [3:0] DEST_NONE     = 4'h0;
	localparam logic [3:0] DEST_WD       = 4'h1;
	localparam logic [3:0] DEST_DEFW     = 4'h2;
	localparam logic [3:0] DEST_FILE     = 4'h3;
	localparam logic [3:0] DEST_PAIR     = 4'h4;
	localparam logic [3:0] DEST_TRADE    = 4'h5;
	localparam logic [3:0] DEST_DIV      = 4'h6;
	localparam logic [3:0] DEST_MEM      = 4'h7;
	localparam logic [3:0] DEST_W32      = 4'h8;

	typedef enum logic [5:0] {
		OP_IDLE, OP_XFER, OP_XFER_LIT8, OP_XFER_LIT16, OP_XFER_LOAD, OP_XFER_STORE,
		OP_XFER_DBL, OP_TRADE, OP_BYTE_SWAP, OP_TBL_RD_HI, OP_TBL_RD_LO,
		OP_TBL_WR_HI, OP_TBL_WR_LO, OP_SUM, OP_SUM_C, OP_DIFF, OP_DIFF_B,
		OP_BDIFF, OP_BDIFF_B, OP_PLUS1, OP_PLUS2, OP_MINUS1, OP_MINUS2, OP_BCD,
		OP_QUO_S, OP_QUO_SL, OP_QUO_U, OP_QUO_UL, OP_QUO_F, OP_PROD_SS,
		OP_PROD_SU, OP_PROD_US, OP_PROD_UU, OP_SEXT, OP_UEXT, OP_AND, OP_OR,
		OP_XOR, OP_ZFILL, OP_OFILL, OP_INV, OP_NEGATE, OP_HW_LOOP, OP_CALL,
		OP_JUMP, OP_DBL_PULL, OP_DBL_PLACE, OP_RET, OP_RET_INT, OP_RET_LIT, OP_SKIP
	} cme_op_e;

	typedef enum logic [1:0] {FORM_FILE, FORM_LIT10, FORM_LIT5, FORM_REGS} cme_form_e;
endpackage

// ### logic/cme_div_step.sv
// one restoring division iteration: shift in one dividend bit, try the subtract
`timescale 1ns/1ns
module cme_div_step #(
	parameter int W = 16
) (
	// partial state in
	input  wire logic [W-1:0] rem_in,
	input  wire logic [W-1:0] quo_in,
	input  wire logic [W-1:0] dvs,
	// partial state out
	output logic      [W-1:0] rem_out,
	output logic      [W-1:0] quo_out
);
	logic [W:0] trial;
	logic [W:0] diff;
	logic       fits;

	assign trial   = {rem_in, quo_in[W-1]};
	assign diff    = trial - {1'b0, dvs};
	assign fits    = trial >= {1'b0, dvs};
	assign rem_out = fits ? diff[W-1:0] : trial[W-1:0];
	assign quo_out = {quo_in[W-2:0], fits};
endmodule

// ### logic/cme_exec.sv
// execution datapath and cycle timing for move, math and logic instructions
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module cme_exec (
	// clock, reset and enable
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// instruction issue
	input  wire logic         op_valid,
	input  cme_pkg::cme_op_e  op_code,
	input  cme_pkg::cme_form_e op_form,
	input  wire logic         byte_mode,
	input  wire logic         to_defw,
	output logic              op_ready,
	// flow context
	input  wire logic         pc_change,
	input  wire logic         skip_taken,
	input  wire logic         skip_two_word,
	input  wire logic         exc_pending,
	input  wire logic         win_access,
	input  wire logic         win_two_wait,
	input  wire logic         repeat_later,
	// operands
	input  wire logic [15:0]  base_val,
	input  wire logic [15:0]  src_val,
	input  wire logic [15:0]  src_hi,
	input  wire logic [15:0]  defw_val,
	input  wire logic [15:0]  lit_val,
	input  wire logic [15:0]  mem_rdata,
	input  wire logic [23:0]  prog_word,
	// results
	output logic              result_valid,
	output logic [15:0]       result_lo,
	output logic [15:0]       result_hi,
	output logic [3:0]        result_dest,
	output logic [15:0]       eff_addr,
	output logic [15:0]       tbl_wdata,
	output logic              tbl_wr_hi,
	output logic              tbl_wr_lo,
	// status and timing
	output logic              carry_flag,
	output logic [2:0]        instr_cycles,
	output logic [1:0]        instr_words,
	output logic              exec_nop,
	output logic              div_busy
);
	typedef enum logic {ST_RUN, ST_HOLD} cme_state_e;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	cme_state_e   state_r;
	logic [2:0]   left_r, nop_cnt_r, cyc_n, nop_n;
	logic [1:0]   words_n;
	logic         take, is_div, bwd;
	logic         carry_r, dc_r, c_wr, c_nxt, dc_nxt, has_res;
	logic [15:0]  b_opnd, uni, ta, tb, add_a, add_b, sum_res, res_lo, res_hi;
	logic         add_ci, sum_c;
	logic [16:0]  sum17;
	logic [8:0]   sum9, bcd1, bcd2;
	logic [4:0]   nib5;
	logic         bcd_hi_sel;
	logic         pa_s, pb_s;
	logic signed [33:0] prod;
	logic [3:0]   dest_f, dest_nxt;
	logic [4:0]   div_cnt_r;
	logic [15:0]  rem_r, quo_r, dvs_r, rem_s, quo_s, q_fin, r_fin;
	logic         qneg_r, rneg_r, d_sgn, n_minus, d_minus;
	logic [31:0]  dvd32, dmag32;
	logic [15:0]  dmag16;
	logic [15:0]  result_lo_r, result_hi_r, tbl_wdata_r;
	logic [3:0]   result_dest_r;
	logic         result_valid_r, tbl_wr_hi_r, tbl_wr_lo_r;
	logic [2:0]   instr_cycles_r;
	logic [1:0]   instr_words_r;

	assign op_ready = state_r == ST_RUN;
	assign take     = op_valid && op_ready && ce;
	assign is_div   = op_code inside {cme_pkg::OP_QUO_S, cme_pkg::OP_QUO_SL,
		cme_pkg::OP_QUO_U, cme_pkg::OP_QUO_UL, cme_pkg::OP_QUO_F};
	assign bwd      = op_code inside {cme_pkg::OP_BDIFF, cme_pkg::OP_BDIFF_B};

	////////////////////////////////////////////////////////////////////////////
	// operand selection
	always_comb begin
		unique case (op_form)
			cme_pkg::FORM_FILE:  b_opnd = defw_val;
			cme_pkg::FORM_LIT10: b_opnd = {6'h00, lit_val[9:0]};
			cme_pkg::FORM_LIT5:  b_opnd = {11'h000, lit_val[4:0]};
			cme_pkg::FORM_REGS:  b_opnd = src_val;
		endcase
	end
	assign uni    = (op_form == cme_pkg::FORM_FILE) ? base_val : src_val;
	assign ta     = bwd ? b_opnd : base_val;
	assign tb     = bwd ? base_val : b_opnd;
	assign dest_f = (op_form != cme_pkg::FORM_FILE) ? cme_pkg::DEST_WD :
		to_defw ? cme_pkg::DEST_DEFW : cme_pkg::DEST_FILE;

	////////////////////////////////////////////////////////////////////////////
	// shared adder
	always_comb begin
		add_a  = ta;
		add_b  = tb;
		add_ci = 1'b0;
		unique case (op_code)
			cme_pkg::OP_SUM_C: add_ci = carry_r;
			cme_pkg::OP_DIFF, cme_pkg::OP_BDIFF: begin
				add_b  = ~tb;
				add_ci = 1'b1;
			end
			cme_pkg::OP_DIFF_B, cme_pkg::OP_BDIFF_B: begin
				add_b  = ~tb;
				add_ci = carry_r;
			end
			cme_pkg::OP_PLUS1, cme_pkg::OP_PLUS2: begin
				add_a = uni;
				add_b = (op_code == cme_pkg::OP_PLUS2) ? 16'h0002 : 16'h0001;
			end
			cme_pkg::OP_MINUS1, cme_pkg::OP_MINUS2: begin
				add_a  = uni;
				add_b  = (op_code == cme_pkg::OP_MINUS2) ? 16'hfffd : 16'hfffe;
				add_ci = 1'b1;
			end
			cme_pkg::OP_NEGATE: begin
				add_a  = ~uni;
				add_b  = cme_pkg::FILL_ZERO;
				add_ci = 1'b1;
			end
			default: add_ci = 1'b0;
		endcase
	end
	assign sum17   = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, add_ci};
	assign sum9    = {1'b0, add_a[7:0]} + {1'b0, add_b[7:0]} + {8'h00, add_ci};
	assign nib5    = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
	// byte results leave the upper lane zero; the writer merges the lane
	assign sum_res = byte_mode ? {8'h00, sum9[7:0]} : sum17[15:0];
	assign sum_c   = byte_mode ? sum9[8] : sum17[16];

	// decimal adjust of the low byte
	assign bcd1 = {1'b0, uni[7:0]} +
		((uni[3:0] > cme_pkg::BCD_LIMIT || dc_r) ? cme_pkg::BCD_ADJ_LO : 9'h000);
	assign bcd_hi_sel = bcd1[7:4] > cme_pkg::BCD_LIMIT || carry_r || bcd1[8];
	assign bcd2 = {1'b0, bcd1[7:0]} + (bcd_hi_sel ? cme_pkg::BCD_ADJ_HI : 9'h000);

	// product operands widened by one sign bit each
	assign pa_s = op_code inside {cme_pkg::OP_PROD_SS, cme_pkg::OP_PROD_SU};
	assign pb_s = op_code inside {cme_pkg::OP_PROD_SS, cme_pkg::OP_PROD_US};
	assign prod = $signed({pa_s & base_val[15], base_val}) *
		$signed({pb_s & b_opnd[15], b_opnd});

	////////////////////////////////////////////////////////////////////////////
	// result selection
	always_comb begin
		res_lo   = cme_pkg::FILL_ZERO;
		res_hi   = cme_pkg::FILL_ZERO;
		dest_nxt = dest_f;
		c_wr     = 1'b0;
		c_nxt    = sum_c;
		dc_nxt   = nib5[4];
		has_res  = 1'b1;
		unique case (op_code)
			cme_pkg::OP_XFER: res_lo = uni;
			cme_pkg::OP_XFER_LIT8: res_lo = {8'h00, lit_val[7:0]};
			cme_pkg::OP_XFER_LIT16: res_lo = lit_val;
			cme_pkg::OP_XFER_LOAD: res_lo = mem_rdata;
			cme_pkg::OP_XFER_STORE: begin
				res_lo   = src_val;
				dest_nxt = cme_pkg::DEST_MEM;
			end
			cme_pkg::OP_XFER_DBL: begin
				res_lo   = src_val;
				res_hi   = src_hi;
				dest_nxt = cme_pkg::DEST_PAIR;
			end
			cme_pkg::OP_TRADE: begin
				res_lo   = src_val;
				res_hi   = base_val;
				dest_nxt = cme_pkg::DEST_TRADE;
			end
			cme_pkg::OP_BYTE_SWAP: res_lo = byte_mode ? {8'h00, uni[3:0], uni[7:4]} :
				{uni[7:0], uni[15:8]};
			cme_pkg::OP_TBL_RD_HI: res_lo = {8'h00, prog_word[23:16]};
			cme_pkg::OP_TBL_RD_LO: res_lo = prog_word[15:0];
			cme_pkg::OP_TBL_WR_HI, cme_pkg::OP_TBL_WR_LO: begin
				dest_nxt = cme_pkg::DEST_NONE;
				has_res  = 1'b0;
			end
			cme_pkg::OP_SUM, cme_pkg::OP_SUM_C, cme_pkg::OP_DIFF, cme_pkg::OP_DIFF_B,
			cme_pkg::OP_BDIFF, cme_pkg::OP_BDIFF_B, cme_pkg::OP_PLUS1, cme_pkg::OP_PLUS2,
			cme_pkg::OP_MINUS1, cme_pkg::OP_MINUS2, cme_pkg::OP_NEGATE: begin
				res_lo = sum_res;
				c_wr   = 1'b1;
			end
			cme_pkg::OP_BCD: begin
				res_lo = {8'h00, bcd2[7:0]};
				c_wr   = 1'b1;
				c_nxt  = bcd_hi_sel;
				dc_nxt = dc_r;
			end
			cme_pkg::OP_QUO_S, cme_pkg::OP_QUO_SL, cme_pkg::OP_QUO_U, cme_pkg::OP_QUO_UL,
			cme_pkg::OP_QUO_F: begin
				res_lo   = q_fin;
				res_hi   = r_fin;
				dest_nxt = cme_pkg::DEST_DIV;
				has_res  = div_cnt_r == cme_pkg::DIV_LAST;
			end
			cme_pkg::OP_PROD_SS, cme_pkg::OP_PROD_SU, cme_pkg::OP_PROD_US,
			cme_pkg::OP_PROD_UU: begin
				res_lo   = prod[15:0];
				res_hi   = prod[31:16];
				dest_nxt = (op_form == cme_pkg::FORM_FILE) ? cme_pkg::DEST_W32 :
					cme_pkg::DEST_PAIR;
			end
			cme_pkg::OP_SEXT: res_lo = {{8{uni[7]}}, uni[7:0]};
			cme_pkg::OP_UEXT: res_lo = {8'h00, uni[7:0]};
			cme_pkg::OP_AND: res_lo = ta & tb;
			cme_pkg::OP_OR: res_lo = ta | tb;
			cme_pkg::OP_XOR: res_lo = ta ^ tb;
			cme_pkg::OP_ZFILL: res_lo = cme_pkg::FILL_ZERO;
			cme_pkg::OP_OFILL: res_lo = cme_pkg::FILL_ONES;
			cme_pkg::OP_INV: res_lo = ~uni;
			cme_pkg::OP_RET_LIT: begin
				res_lo   = lit_val;
				dest_nxt = cme_pkg::DEST_WD;
			end
			default: begin
				dest_nxt = cme_pkg::DEST_NONE;
				has_res  = 1'b0;
			end
		endcase
		if (byte_mode && op_code inside {cme_pkg::OP_AND, cme_pkg::OP_OR,
			cme_pkg::OP_XOR, cme_pkg::OP_INV, cme_pkg::OP_XFER}) begin
			res_lo = {8'h00, res_lo[7:0]};
		end
	end

	// flags
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			carry_r <= cme_pkg::CARRY_RST;
			dc_r    <= cme_pkg::DC_RST;
		end else if (take && c_wr) begin
			carry_r <= c_nxt;
			dc_r    <= dc_nxt;
		end
	end
	assign carry_flag = carry_r;

	carry_track_a: assert property (take && op_code == cme_pkg::OP_SUM && !byte_mode
		|=> carry_flag == $past(sum17[16])) else $error("carry not from top bit");
	negate_value_a: assert property (take && op_code == cme_pkg::OP_NEGATE && !byte_mode
		|=> result_lo == 16'(~$past(uni) + 16'h0001)) else $error("negate wrong");

	////////////////////////////////////////////////////////////////////////////
	// divide sequencer: pass 0 loads magnitudes, 1..16 step, 17 signs the result
	always_comb begin
		d_sgn = op_code inside {cme_pkg::OP_QUO_S, cme_pkg::OP_QUO_SL, cme_pkg::OP_QUO_F};
		unique case (op_code)
			cme_pkg::OP_QUO_SL, cme_pkg::OP_QUO_UL: dvd32 = {src_hi, base_val};
			cme_pkg::OP_QUO_F: dvd32 = {base_val[15], base_val, 15'h0000};
			cme_pkg::OP_QUO_S: dvd32 = {{16{base_val[15]}}, base_val};
			default: dvd32 = {16'h0000, base_val};
		endcase
		n_minus = d_sgn && dvd32[31];
		d_minus = d_sgn && src_val[15];
		dmag32  = n_minus ? (~dvd32 + 32'h0000_0001) : dvd32;
		dmag16  = d_minus ? (~src_val + 16'h0001) : src_val;
	end
	assign q_fin = qneg_r ? (~quo_r + 16'h0001) : quo_r;
	assign r_fin = rneg_r ? (~rem_r + 16'h0001) : rem_r;

	cme_div_step #(
		.W       (16)
	) u_step (
		.rem_in  (rem_r),
		.quo_in  (quo_r),
		.dvs     (dvs_r),
		.rem_out (rem_s),
		.quo_out (quo_s)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_cnt_r <= cme_pkg::DIV_CNT_RST;
		end else if (take) begin
			// an interrupted divide sequence restarts from the load pass
			if (!is_div || div_cnt_r == cme_pkg::DIV_LAST) begin
				div_cnt_r <= cme_pkg::DIV_CNT_RST;
			end else begin
				div_cnt_r <= div_cnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rem_r  <= cme_pkg::FILL_ZERO;
			quo_r  <= cme_pkg::FILL_ZERO;
			dvs_r  <= cme_pkg::FILL_ZERO;
			qneg_r <= 1'b0;
			rneg_r <= 1'b0;
		end else if (take && is_div) begin
			if (div_cnt_r == cme_pkg::DIV_CNT_RST) begin
				rem_r  <= dmag32[31:16];
				quo_r  <= dmag32[15:0];
				dvs_r  <= dmag16;
				qneg_r <= n_minus ^ d_minus;
				rneg_r <= n_minus;
			end else if (div_cnt_r <= cme_pkg::DIV_STEP_LAST) begin
				rem_r <= rem_s;
				quo_r <= quo_s;
			end
		end
	end
	assign div_busy = div_cnt_r != cme_pkg::DIV_CNT_RST;

	div_finish_a: assert property (take && is_div && div_cnt_r == cme_pkg::DIV_LAST
		|=> result_valid && result_dest == cme_pkg::DEST_DIV && !div_busy)
		else $error("divide did not finish on pass eighteen");
	div_quiet_a: assert property (take && is_div && div_cnt_r < cme_pkg::DIV_LAST
		|=> !result_valid && div_busy) else $error("early divide result");

	////////////////////////////////////////////////////////////////////////////
	// cycle and word counts
	always_comb begin
		cyc_n   = cme_pkg::CYC_ONE;
		nop_n   = cme_pkg::CYC_NONE;
		words_n = cme_pkg::WORDS_ONE;
		unique case (op_code)
			cme_pkg::OP_XFER_DBL, cme_pkg::OP_TBL_RD_HI, cme_pkg::OP_TBL_RD_LO,
			cme_pkg::OP_TBL_WR_HI, cme_pkg::OP_TBL_WR_LO, cme_pkg::OP_DBL_PULL,
			cme_pkg::OP_DBL_PLACE: cyc_n = cme_pkg::CYC_TWO;
			cme_pkg::OP_HW_LOOP: begin
				cyc_n   = cme_pkg::CYC_TWO;
				words_n = cme_pkg::WORDS_TWO;
			end
			cme_pkg::OP_CALL, cme_pkg::OP_JUMP: begin
				cyc_n   = cme_pkg::CYC_TWO;
				nop_n   = cme_pkg::CYC_ONE;
				words_n = cme_pkg::WORDS_TWO;
			end
			cme_pkg::OP_RET, cme_pkg::OP_RET_INT, cme_pkg::OP_RET_LIT: begin
				cyc_n = exc_pending ? cme_pkg::CYC_TWO : cme_pkg::CYC_THREE;
				nop_n = exc_pending ? cme_pkg::CYC_ONE : cme_pkg::CYC_TWO;
			end
			cme_pkg::OP_SKIP: begin
				if (skip_taken) begin
					cyc_n = skip_two_word ? cme_pkg::CYC_THREE : cme_pkg::CYC_TWO;
					nop_n = skip_two_word ? cme_pkg::CYC_TWO : cme_pkg::CYC_ONE;
				end
			end
			default: begin
				if (pc_change) begin
					cyc_n = cme_pkg::CYC_TWO;
					nop_n = cme_pkg::CYC_ONE;
				end
			end
		endcase
		// window wait stalls come before any trailing no-operation cycles
		if (win_access && !repeat_later) begin
			cyc_n = cyc_n + (win_two_wait ? cme_pkg::CYC_TWO : cme_pkg::CYC_ONE);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r   <= ST_RUN;
			left_r    <= cme_pkg::CYC_NONE;
			nop_cnt_r <= cme_pkg::CYC_NONE;
		end else if (ce) begin
			unique case (state_r)
				ST_RUN: begin
					if (op_valid && cyc_n > cme_pkg::CYC_ONE) begin
						state_r   <= ST_HOLD;
						left_r    <= cyc_n - cme_pkg::CYC_ONE;
						nop_cnt_r <= nop_n;
					end
				end
				ST_HOLD: begin
					left_r <= left_r - cme_pkg::CYC_ONE;
					if (left_r == cme_pkg::CYC_ONE) begin
						state_r <= ST_RUN;
					end
				end
			endcase
		end
	end
	assign exec_nop = state_r == ST_HOLD && left_r <= nop_cnt_r;

	single_cycle_a: assert property (take && op_code == cme_pkg::OP_SUM && !pc_change
		&& !win_access |=> op_ready) else $error("plain op held the pipe");
	two_cycle_a: assert property ((take && op_code == cme_pkg::OP_TBL_RD_LO && !win_access)
		##1 ce |-> !op_ready && !exec_nop ##1 op_ready) else $error("table op not two");
	jump_nop_a: assert property ((take && op_code == cme_pkg::OP_JUMP && !win_access)
		|=> exec_nop && instr_words == cme_pkg::WORDS_TWO)
		else $error("jump timing or size wrong");
	skip_nops_a: assert property ((take && op_code == cme_pkg::OP_SKIP && skip_taken
		&& skip_two_word && !win_access) ##1 ce |-> exec_nop ##1 exec_nop ##1 op_ready)
		else $error("two-word skip not three cycles");
	return_len_a: assert property (take && op_code == cme_pkg::OP_RET && !win_access
		|=> instr_cycles == ($past(exc_pending) ? cme_pkg::CYC_TWO : cme_pkg::CYC_THREE))
		else $error("return length wrong");
	window_wait_a: assert property (take && op_code == cme_pkg::OP_XFER && win_access
		&& !repeat_later && !pc_change |=> instr_cycles ==
		($past(win_two_wait) ? cme_pkg::CYC_THREE : cme_pkg::CYC_TWO))
		else $error("window wait wrong");

	////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_valid_r <= 1'b0;
			result_lo_r    <= cme_pkg::FILL_ZERO;
			result_hi_r    <= cme_pkg::FILL_ZERO;
			result_dest_r  <= cme_pkg::DEST_NONE;
			tbl_wdata_r    <= cme_pkg::FILL_ZERO;
			tbl_wr_hi_r    <= 1'b0;
			tbl_wr_lo_r    <= 1'b0;
			instr_cycles_r <= cme_pkg::CYC_NONE;
			instr_words_r  <= cme_pkg::WORDS_ONE;
		end else if (ce) begin
			result_valid_r <= take && has_res;
			tbl_wr_hi_r    <= take && op_code == cme_pkg::OP_TBL_WR_HI;
			tbl_wr_lo_r    <= take && op_code == cme_pkg::OP_TBL_WR_LO;
			if (take) begin
				result_lo_r    <= res_lo;
				result_hi_r    <= res_hi;
				result_dest_r  <= dest_nxt;
				tbl_wdata_r    <= src_val;
				instr_cycles_r <= cyc_n;
				instr_words_r  <= words_n;
			end
		end
	end
	assign result_valid = result_valid_r;
	assign result_lo    = result_lo_r;
	assign result_hi    = result_hi_r;
	assign result_dest  = result_dest_r;
	assign tbl_wdata    = tbl_wdata_r;
	assign tbl_wr_hi    = tbl_wr_hi_r;
	assign tbl_wr_lo    = tbl_wr_lo_r;
	assign instr_cycles = instr_cycles_r;
	assign instr_words  = instr_words_r;
	// address for indirect transfers is combinational so memory answers in-cycle
	assign eff_addr = base_val + {{6{lit_val[9]}}, lit_val[9:0]};

	file_dest_a: assert property (take && op_code == cme_pkg::OP_XOR
		&& op_form == cme_pkg::FORM_FILE |=> result_dest ==
		($past(to_defw) ? cme_pkg::DEST_DEFW : cme_pkg::DEST_FILE))
		else $error("file form destination wrong");
	fill_ones_a: assert property (take && op_code == cme_pkg::OP_OFILL
		|=> result_valid && result_lo == cme_pkg::FILL_ONES)
		else $error("ones fill wrong");
endmodule

// ### tb/tb_top.sv
// self-checking bench for the move/math/logic execution datapath
`timescale 1ns/1ns
module tb_top;
	logic               ref_clk  = 1'b0;
	logic               rst      = 1'b1;
	logic               op_valid = 1'b0;
	cme_pkg::cme_op_e   op_code  = cme_pkg::OP_IDLE;
	cme_pkg::cme_form_e op_form  = cme_pkg::FORM_REGS;
	logic [7:0]         fl       = 8'h00;
	logic [15:0]        a_v      = 16'h0000;
	logic [15:0]        b_v      = 16'h0000;
	logic [15:0]        hi_v     = 16'h0000;
	logic               op_ready;
	logic               result_valid;
	logic               carry_flag;
	logic [15:0]        res_lo;
	logic [15:0]        res_hi;
	logic [3:0]         res_dest;
	logic [1:0]         words;
	logic               bm       = 1'b0;
	logic               byte_sel = 1'b0;
	logic [15:0]        eff_addr;
	logic [15:0]        tbl_wdata;
	logic               tbl_wr_hi;
	logic               tbl_wr_lo;
	logic [2:0]         cycles;
	logic               div_busy;
	int                 err_total = 0;
	int                 tests_run = 0;
	int                 cyc_n     = 0;
////////////////////////////////////////////////////////////////////////////////
	always #20 ref_clk = ~ref_clk;
	// flag order: to_defw, pc change, skip, skip two-word, exception, window, two wait, repeat
	cme_exec cme_exec_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .op_valid(op_valid),
		.op_code(op_code), .op_form(op_form), .byte_mode(bm), .to_defw(fl[7]),
		.op_ready(op_ready), .pc_change(fl[6]), .skip_taken(fl[5]), .skip_two_word(fl[4]),
		.exc_pending(fl[3]), .win_access(fl[2]), .win_two_wait(fl[1]), .repeat_later(fl[0]),
		.base_val(a_v), .src_val(b_v), .src_hi(hi_v), .defw_val(b_v), .lit_val(b_v),
		.mem_rdata(16'h1234), .prog_word(24'h5aabcd), .result_valid(result_valid),
		.result_lo(res_lo), .result_hi(res_hi), .result_dest(res_dest), .eff_addr(eff_addr),
		.tbl_wdata(tbl_wdata), .tbl_wr_hi(tbl_wr_hi), .tbl_wr_lo(tbl_wr_lo),
		.carry_flag(carry_flag), .instr_cycles(cycles), .instr_words(words), .exec_nop(),
		.div_busy(div_busy));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [39:0] got, logic [39:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// waits out any busy op, so a request is never left pending into a hold cycle
	task automatic go(cme_pkg::cme_op_e o, cme_pkg::cme_form_e f, logic [7:0] g,
		logic [15:0] a, logic [15:0] b);
		while (op_ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		op_code <= o;
		op_form <= f;
		fl <= g;
		bm <= byte_sel;
		a_v <= a;
		b_v <= b;
		op_valid <= 1'b1;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
	endtask
	task automatic alu(cme_pkg::cme_op_e o, logic [15:0] a, logic [15:0] b, logic [15:0] e);
		go(o, cme_pkg::FORM_REGS, 8'h00, a, b);
		chk("alu", res_lo, e);
	endtask
	task automatic cyc(cme_pkg::cme_op_e o, logic [7:0] g, int n, logic [1:0] w);
		int k;
		k = 0;
		go(o, cme_pkg::FORM_REGS, g, 16'h0001, 16'h0002);
		chk("words", words, w);
		chk("cycles", cycles, n + 1);
		while (op_ready !== 1'b1 && k < 9) begin
			k++;
			@(posedge ref_clk);
			#1;
		end
		chk("extra", k, n);
	endtask
	// the divide is held valid so the 18 takes come back to back
	task automatic dv(cme_pkg::cme_op_e o, logic [15:0] h, logic [15:0] a, logic [15:0] b,
		logic [31:0] e);
		@(posedge ref_clk);
		op_code <= o;
		fl <= 8'h00;
		hi_v <= h;
		a_v <= a;
		b_v <= b;
		op_valid <= 1'b1;
		repeat (9) @(posedge ref_clk);
		#1;
		chk("busy", div_busy, 1'b1);
		repeat (9) @(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		chk("quot", {res_dest, res_hi, res_lo}, {cme_pkg::DEST_DIV, e});
	endtask
////////////////////////////////////////////////////////////////////////////////
	task automatic s_alu;
		go(cme_pkg::OP_SUM, cme_pkg::FORM_REGS, 8'h00, 16'hffff, 16'h0001);
		chk("sum", {result_valid, carry_flag, res_lo}, 18'h30000);
		alu(cme_pkg::OP_SUM_C, 16'h0001, 16'h0001, 16'h0003);
		alu(cme_pkg::OP_DIFF_B, 16'h0005, 16'h0002, 16'h0002);
		alu(cme_pkg::OP_BDIFF, 16'h0002, 16'h0005, 16'h0003);
		go(cme_pkg::OP_AND, cme_pkg::FORM_LIT5, 8'h00, 16'h00f1, 16'h0013);
		chk("lit5", res_lo, 16'h0011);
		go(cme_pkg::OP_SUM, cme_pkg::FORM_LIT10, 8'h00, 16'h0001, 16'hfc00);
		chk("lit10", res_lo, 16'h0001);
		alu(cme_pkg::OP_XOR, 16'hf0f0, 16'hff00, 16'h0ff0);
		alu(cme_pkg::OP_ZFILL, 16'h1234, 16'h1234, 16'h0000);
		alu(cme_pkg::OP_OFILL, 16'h1234, 16'h1234, 16'hffff);
		alu(cme_pkg::OP_INV, 16'hf0f0, 16'hf0f0, 16'h0f0f);
		alu(cme_pkg::OP_NEGATE, 16'h0001, 16'h0001, 16'hffff);
		alu(cme_pkg::OP_SEXT, 16'h0080, 16'h0080, 16'hff80);
		alu(cme_pkg::OP_UEXT, 16'hff80, 16'hff80, 16'h0080);
		alu(cme_pkg::OP_PLUS2, 16'hfffe, 16'hfffe, 16'h0000);
		go(cme_pkg::OP_TRADE, cme_pkg::FORM_REGS, 8'h00, 16'h1111, 16'h2222);
		chk("trade", {res_hi, res_lo}, 32'h11112222);
		alu(cme_pkg::OP_PLUS1, 16'h00ff, 16'h00ff, 16'h0100);
		alu(cme_pkg::OP_MINUS1, 16'h0000, 16'h0000, 16'hffff);
		alu(cme_pkg::OP_MINUS2, 16'h0003, 16'h0003, 16'h0001);
		go(cme_pkg::OP_PROD_UU, cme_pkg::FORM_REGS, 8'h00, 16'hffff, 16'hffff);
		chk("prod", {res_hi, res_lo}, 32'hfffe0001);
		go(cme_pkg::OP_SUM, cme_pkg::FORM_FILE, 8'h80, 16'h0003, 16'h0004);
		chk("dst", {res_dest, res_lo}, {cme_pkg::DEST_DEFW, 16'h0007});
		go(cme_pkg::OP_SUM, cme_pkg::FORM_FILE, 8'h00, 16'h0003, 16'h0004);
		chk("dst", res_dest, cme_pkg::DEST_FILE);
		go(cme_pkg::OP_XOR, cme_pkg::FORM_FILE, 8'h80, 16'hf0f0, 16'h0ff0);
		chk("xdst", {res_dest, res_lo}, {cme_pkg::DEST_DEFW, 16'hff00});
	endtask
	// byte lane results, nibble swap and decimal adjust after a word sum
	task automatic s_byte;
		byte_sel = 1'b1;
		go(cme_pkg::OP_SUM, cme_pkg::FORM_REGS, 8'h00, 16'h12ff, 16'h3401);
		chk("bsum", {carry_flag, res_lo}, 17'h10000);
		alu(cme_pkg::OP_BYTE_SWAP, 16'h00a5, 16'h12a5, 16'h005a);
		byte_sel = 1'b0;
		alu(cme_pkg::OP_BYTE_SWAP, 16'h1234, 16'h1234, 16'h3412);
		alu(cme_pkg::OP_SUM, 16'h0009, 16'h0008, 16'h0011);
		alu(cme_pkg::OP_BCD, 16'h0011, 16'h0011, 16'h0017);
	endtask
	task automatic s_mem;
		go(cme_pkg::OP_XFER_LOAD, cme_pkg::FORM_REGS, 8'h00, 16'h1000, 16'h03ff);
		chk("load", {eff_addr, res_lo}, 32'h0fff1234);
		go(cme_pkg::OP_XFER_STORE, cme_pkg::FORM_REGS, 8'h00, 16'h2000, 16'h0010);
		chk("st", {res_dest, eff_addr, res_lo}, {cme_pkg::DEST_MEM, 32'h20100010});
		alu(cme_pkg::OP_XFER_LIT8, 16'h0000, 16'h1234, 16'h0034);
		alu(cme_pkg::OP_XFER_LIT16, 16'h0000, 16'h1234, 16'h1234);
		alu(cme_pkg::OP_TBL_RD_HI, 16'h0000, 16'h0000, 16'h005a);
		alu(cme_pkg::OP_TBL_RD_LO, 16'h0000, 16'h0000, 16'habcd);
		go(cme_pkg::OP_TBL_WR_HI, cme_pkg::FORM_REGS, 8'h00, 16'h0000, 16'hbeef);
		chk("twr", {tbl_wr_hi, tbl_wr_lo, result_valid, tbl_wdata}, 19'h4beef);
	endtask
	task automatic s_cyc;
		cyc(cme_pkg::OP_SUM, 8'h00, 0, 1);
		cyc(cme_pkg::OP_JUMP, 8'h00, 1, 2);
		cyc(cme_pkg::OP_HW_LOOP, 8'h00, 1, 2);
		cyc(cme_pkg::OP_XFER_DBL, 8'h00, 1, 1);
		cyc(cme_pkg::OP_TBL_RD_LO, 8'h00, 1, 1);
		cyc(cme_pkg::OP_DBL_PULL, 8'h00, 1, 1);
		cyc(cme_pkg::OP_SUM, 8'h40, 1, 1);
		cyc(cme_pkg::OP_SKIP, 8'h30, 2, 1);
		cyc(cme_pkg::OP_RET, 8'h00, 2, 1);
		cyc(cme_pkg::OP_RET_LIT, 8'h08, 1, 1);
		cyc(cme_pkg::OP_XFER, 8'h04, 1, 1);
		cyc(cme_pkg::OP_XFER, 8'h06, 2, 1);
		cyc(cme_pkg::OP_XFER, 8'h07, 0, 1);
	endtask
	task automatic s_div;
		dv(cme_pkg::OP_QUO_U, 16'h0000, 16'h0064, 16'h0007, 32'h0002000e);
		dv(cme_pkg::OP_QUO_S, 16'hffff, 16'hff9c, 16'h0007, 32'hfffefff2);
		dv(cme_pkg::OP_QUO_UL, 16'h0001, 16'h0000, 16'h0002, 32'h00008000);
		dv(cme_pkg::OP_QUO_SL, 16'hffff, 16'hff9c, 16'h0007, 32'hfffefff2);
		dv(cme_pkg::OP_QUO_F, 16'h0000, 16'h2000, 16'h4000, 32'h00004000);
	endtask
////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			err_total++;
			finish_test;
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		s_alu;
		s_byte;
		s_mem;
		s_cyc;
		s_div;
		finish_test;
	end
endmodule
